// ### core/crl_pkg.sv
package crl_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [4:0]  CTRL_OFS       = 5'h0c;
    localparam logic [4:0]  DATA_OFS       = 5'h10;
    localparam logic [4:0]  RESULT_OFS     = 5'h14;
    localparam logic [4:0]  XOR_OFS        = 5'h18;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          ORDER_BIT      = 1;
    localparam int          WIPE_BIT       = 2;
    localparam int          CRC_W          = 16;
    localparam int          BYTE_W         = 8;
    localparam logic [15:0] CRC_POLY       = 16'h8005;
    localparam logic [15:0] CRC_RESET      = 16'h0000;
    localparam logic [7:0]  XOR_RESET      = 8'h00;
    localparam logic        ORDER_RESET    = 1'b0;

    // ------------------------------------------------------------
    // bus encodings
    // ------------------------------------------------------------
    localparam logic [2:0]  SIZE_BYTE      = 3'h0;
    localparam logic [2:0]  SIZE_HALF      = 3'h1;
    localparam logic        RESP_OKAY      = 1'b0;

    // captured address phase of a bus transfer
    typedef struct packed {
        logic       wr;
        logic [4:0] addr;
        logic [3:0] be;
    } crl_aphase_t;

endpackage

// ### core/crl_crc_byte.sv
`timescale 1ns/1ps
// one byte through the crc16 shift register, msb first after optional reversal
module crl_crc_byte
    import crl_pkg::*;
(
    input  wire logic [15:0] i_crc,
    input  wire logic [7:0]  i_byte,
    input  wire logic        i_lsb_first,
    output logic      [15:0] o_crc
);
    logic [7:0]  rev;
    logic [7:0]  din;
    logic [15:0] chain [0:8];

    assign chain[0] = i_crc;

    genvar g;
    generate
        for (g = 0; g < BYTE_W; g++)
        begin : g_bit
            assign rev[g] = i_byte[BYTE_W - 1 - g];
            // stage g absorbs input bit 7-g of the (possibly reversed) byte
            assign chain[g + 1] = chain[g][CRC_W - 1] ^ din[BYTE_W - 1 - g]
                                ? {chain[g][CRC_W - 2:0], 1'b0} ^ CRC_POLY
                                : {chain[g][CRC_W - 2:0], 1'b0};
        end
    endgenerate

    assign din   = i_lsb_first ? rev : i_byte;
    assign o_crc = chain[8];
endmodule

// ### core/crl_unit.sv
// Functional notes
// - crc polynomial is fixed 0x8005
// - one byte in, sixteen bit code out
// - each update completes in one clock
// - control bit 1 picks input bit order
// - control bit 2 clears crc, reads zero
// - writing zero to result bytes 0 and 1 clears it
// - written result seeds next calculation
// - data write updates crc from prior value
// - data write xors byte into check register
// - both checks update together, read separately
// - byte, half and word accesses accepted
// - plain crc16, zero init, no reflection while control bit 1 is clear
`timescale 1ns/1ps
module crl_unit
    import crl_pkg::*;
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    crl_aphase_t ap;
    crl_aphase_t next_ap;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic [7:0]  xor_chk;
    logic [7:0]  next_xor_chk;
    logic        order;
    logic        next_order;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [15:0] stepped;
    logic [3:0]  be;
    logic        take;
    logic        data_wr;
    logic        ctrl_wr;
    logic        result_wr;
    logic        xor_wr;

    // ------------------------------------------------------------
    // address phase
    // ------------------------------------------------------------
    assign take = I_CE & I_HSEL & I_HTRANS[1] & I_HREADY;

    always_comb
    begin
        case (I_HSIZE)
            SIZE_BYTE: be = 4'h1 << I_HADDR[1:0];
            SIZE_HALF: be = I_HADDR[1] ? 4'hc : 4'h3;
            default:   be = 4'hf;
        endcase
    end

    always_comb
    begin
        next_ap = '0;
        if (take)
        begin
            next_ap.wr   = I_HWRITE;
            next_ap.addr = {I_HADDR[4:2], 2'h0};
            next_ap.be   = be;
        end
    end

    // ------------------------------------------------------------
    // data phase writes
    // ------------------------------------------------------------
    assign data_wr   = ap.wr & ap.be[0] & (ap.addr == DATA_OFS);
    assign ctrl_wr   = ap.wr & ap.be[0] & (ap.addr == CTRL_OFS);
    assign result_wr = ap.wr & (ap.addr == RESULT_OFS);
    assign xor_wr    = ap.wr & ap.be[0] & (ap.addr == XOR_OFS);

    crl_crc_byte u_step
    (
        .i_crc       (crc),
        .i_byte      (I_HWDATA[7:0]),
        .i_lsb_first (order),
        .o_crc       (stepped)
    );

    always_comb
    begin
        next_crc     = crc;
        next_xor_chk = xor_chk;
        next_order   = order;
        if (data_wr)
        begin
            next_crc     = stepped;
            next_xor_chk = xor_chk ^ I_HWDATA[7:0];
        end
        if (ctrl_wr)
        begin
            next_order = I_HWDATA[ORDER_BIT];
            if (I_HWDATA[WIPE_BIT])
                next_crc = CRC_RESET;
        end
        if (result_wr)
        begin
            // byte lanes merge so two byte writes load a full seed
            if (ap.be[0])
                next_crc[7:0] = I_HWDATA[7:0];
            if (ap.be[1])
                next_crc[15:8] = I_HWDATA[15:8];
        end
        if (xor_wr)
            next_xor_chk = I_HWDATA[7:0];
    end

    // ------------------------------------------------------------
    // read data, taken from next values so a read right after a write sees it
    // ------------------------------------------------------------
    always_comb
    begin
        next_rdata = rdata;
        if (take)
        begin
            next_rdata = '0;
            if (!I_HWRITE)
            begin
                case ({I_HADDR[4:2], 2'h0})
                    CTRL_OFS:   next_rdata[ORDER_BIT] = next_order;   // wipe bit reads zero
                    RESULT_OFS: next_rdata[15:0] = next_crc;
                    XOR_OFS:    next_rdata[7:0] = next_xor_chk;
                    default:    next_rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ap      <= '0;
            crc     <= CRC_RESET;
            xor_chk <= XOR_RESET;
            order   <= ORDER_RESET;
            rdata   <= '0;
        end
        else if (I_CE)
        begin
            ap      <= next_ap;
            crc     <= next_crc;
            xor_chk <= next_xor_chk;
            order   <= next_order;
            rdata   <= next_rdata;
        end
    end

    assign O_HRDATA    = rdata;
    assign O_HREADYOUT = I_CE;
    assign O_HRESP     = RESP_OKAY;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    crc_poly_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && data_wr && !ctrl_wr && crc == 16'h0000 && !order && I_HWDATA[7:0] == 8'h01)
        |=> crc == 16'h8005)
        else $error("crc of byte 01 from zero is not 8005");

    bit_order_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && data_wr && crc == 16'h0000 && order && I_HWDATA[7:0] == 8'h80)
        |=> crc == 16'h8005)
        else $error("lsb first order not applied");

    zero_byte_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && data_wr && crc == 16'h0000 && I_HWDATA[7:0] == 8'h00)
        |=> crc == 16'h0000)
        else $error("zero byte changed zero crc");

    xor_update_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && data_wr)
        |=> xor_chk == ($past(xor_chk) ^ $past(I_HWDATA[7:0])))
        else $error("check register not xor of byte");

    wipe_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && ctrl_wr && I_HWDATA[WIPE_BIT])
        |=> crc == 16'h0000)
        else $error("wipe did not clear crc");

    wipe_read_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        ##1 O_HRDATA[31:16] == 16'h0000
        && !(O_HRDATA[WIPE_BIT] && $past(take) && !$past(I_HWRITE)
        && $past(I_HADDR[4:2]) == CTRL_OFS[4:2]))
        else $error("reserved or wipe bit read nonzero");

    seed_load_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && result_wr && ap.be[1:0] == 2'h3)
        |=> crc == $past(I_HWDATA[15:0]))
        else $error("result write not loaded");

    crc_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (!(I_CE && (data_wr || ctrl_wr || result_wr)))
        |=> $stable(crc))
        else $error("crc changed without a write");

    both_update_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && data_wr && !ctrl_wr && !result_wr && I_HWDATA[7:0] != 8'h00)
        |=> !$stable(xor_chk))
        else $error("check register missed concurrent update");

    xor_load_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (I_CE && xor_wr)
        |=> xor_chk == $past(I_HWDATA[7:0]))
        else $error("check register not loaded by write");

    // a stalled data phase must not update twice or early
    ce_freeze_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
        (!I_CE)
        |=> $stable(crc) && $stable(xor_chk) && $stable(order))
        else $error("state moved while clock enable low");
endmodule

// ### sim/crl_ahb_master.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus master model: one non-pipelined transfer at a time
// ------------------------------------------------------------
module crl_ahb_master
    import crl_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_ready,
    input  wire logic [31:0] i_rdata,
    output logic             o_sel,
    output logic [31:0]      o_addr,
    output logic [1:0]       o_trans,
    output logic             o_write,
    output logic [2:0]       o_size,
    output logic [31:0]      o_wdata
);
    initial
    begin
        o_sel = 1'b0;
        o_addr = 32'h0;
        o_trans = 2'h0;
        o_write = 1'b0;
        o_size = 3'h2;
        o_wdata = 32'h0;
    end

    // released data lines show the inverse of their last value
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(negedge i_clk);
        o_sel = 1'b1;
        o_trans = 2'h2;
        o_write = wr;
        o_addr = {27'h0, a};
        o_size = sz;
        o_wdata = ~o_wdata;
        @(posedge i_clk);
        while (i_ready !== 1'b1) @(posedge i_clk);
        @(negedge i_clk);
        o_sel = 1'b0;
        o_trans = 2'h0;
        o_addr = ~o_addr;
        o_wdata = wd;
        @(posedge i_clk);
        while (i_ready !== 1'b1) @(posedge i_clk);
        rd = i_rdata;
    endtask
endmodule

// ### sim/crl_unit_tb_top.sv
`timescale 1ns/1ps
module crl_unit_tb_top;
    import crl_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        sel;
    logic        wr;
    logic        ready;
    logic        resp;
    logic [1:0]  trans;
    logic [2:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic [15:0] crc;
    logic [7:0]  lrc;
    logic [7:0]  lf = 8'h46;
    logic        ord;
    int          mismatches = 0;
    int          num_checks = 0;

    always #5 clk = ~clk;

    crl_unit crl_unit_inst (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(ce), .I_HSEL(sel), .I_HADDR(addr),
        .I_HTRANS(trans), .I_HWRITE(wr), .I_HSIZE(size), .I_HWDATA(wdata), .I_HREADY(ready),
        .O_HRDATA(rdata), .O_HREADYOUT(ready), .O_HRESP(resp));
    crl_ahb_master crl_ahb_master_inst (.i_clk(clk), .i_ready(ready), .i_rdata(rdata), .o_sel(sel),
        .o_addr(addr), .o_trans(trans), .o_write(wr), .o_size(size), .o_wdata(wdata));

    // ------------------------------------------------------------
    // reference and helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [7:0] d, input logic lsb);
        logic fb;
        for (int i = 7; i >= 0; i--)
        begin
            fb = c[15] ^ (lsb ? d[7-i] : d[i]);
            c = {c[14:0], 1'b0};
            if (fb) c = c ^ CRC_POLY;
        end
        return c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_t(input logic [4:0] a, input logic [2:0] sz, input logic [31:0] d);
        crl_ahb_master_inst.xfer(1'b1, a, sz, d, rd);
    endtask

    task automatic rd_t(input logic [4:0] a, input logic [31:0] exp);
        crl_ahb_master_inst.xfer(1'b0, a, 3'h2, 32'h0, rd);
        chk(rd, exp);
        chk({31'h0, resp}, 32'h0);
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        #100000;
        mismatches++;
        summarize;
    end

    initial
    begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 3; i < 8; i++) rd_t(5'(i * 4), 32'h0);
        $display("test reset done");
        lrc = 8'h5a;
        crc = 16'hc3a1;
        wr_t(XOR_OFS, SIZE_BYTE, {4{lrc}});
        wr_t(RESULT_OFS + 5'h1, SIZE_BYTE, {4{crc[15:8]}});
        wr_t(RESULT_OFS, SIZE_BYTE, {4{crc[7:0]}});
        rd_t(RESULT_OFS, {16'h0, crc});
        rd_t(XOR_OFS, {24'h0, lrc});
        for (int n = 0; n < 40; n++)
        begin
            lf = lfsr(lf);
            if (n % 8 == 0)
            begin
                ord = n[3];
                wr_t(CTRL_OFS, 3'h2, {16'hffff, 13'h0, 1'b0, ord, 1'b1});
                rd_t(CTRL_OFS, {30'h0, ord, 1'b0});
            end
            wr_t(DATA_OFS, 3'h2, {~lf, lf, ~lf, lf});
            crc = crc_f(crc, lf, ord);
            lrc = lrc ^ lf;
            rd_t(RESULT_OFS, {16'h0, crc});
            rd_t(XOR_OFS, {24'h0, lrc});
        end
        rd_t(DATA_OFS, 32'h0);
        $display("test stream done");
        wr_t(CTRL_OFS, 3'h2, 32'h4);
        rd_t(CTRL_OFS, 32'h0);
        rd_t(RESULT_OFS, 32'h0);
        rd_t(XOR_OFS, {24'h0, lrc});
        wr_t(DATA_OFS, SIZE_BYTE, {4{8'h31}});
        rd_t(RESULT_OFS, {16'h0, crc_f(16'h0, 8'h31, 1'b0)});
        // corner bytes from a cleared result, both bit orders
        wr_t(CTRL_OFS, 3'h2, 32'h4);
        wr_t(DATA_OFS, SIZE_BYTE, 32'h0);
        rd_t(RESULT_OFS, 32'h0);
        wr_t(DATA_OFS, SIZE_BYTE, 32'h1);
        rd_t(RESULT_OFS, {16'h0, crc_f(16'h0, 8'h01, 1'b0)});
        wr_t(CTRL_OFS, 3'h2, 32'h6);
        wr_t(DATA_OFS, SIZE_BYTE, 32'h80);
        rd_t(RESULT_OFS, {16'h0, crc_f(16'h0, 8'h80, 1'b1)});
        wr_t(CTRL_OFS, 3'h2, 32'h0);
        wr_t(RESULT_OFS, SIZE_HALF, 32'h0);
        rd_t(RESULT_OFS, 32'h0);
        wr_t(5'h1c, 3'h2, 32'hffffffff);
        rd_t(5'h1c, 32'h0);
        rd_t(RESULT_OFS, 32'h0);
        $display("test clear done");
        // clock enable drops in the data phase of a write and stalls it
        fork
            wr_t(DATA_OFS, SIZE_BYTE, {4{8'h5b}});
            begin
                repeat (2) @(negedge clk);
                ce = 1'b0;
                repeat (2) @(negedge clk);
                chk({31'h0, ready}, 32'h0);
                ce = 1'b1;
            end
        join
        rd_t(RESULT_OFS, {16'h0, crc_f(16'h0, 8'h5b, 1'b0)});
        $display("test freeze done");
        wr_t(CTRL_OFS, 3'h2, 32'h2);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        for (int i = 3; i < 7; i++) rd_t(5'(i * 4), 32'h0);
        $display("test midreset done");
        summarize;
    end
endmodule
